// ===== fpm_params.svh
/*
 * Constants of the front-panel monitor: register offsets, field
 * positions, reset values and encoder limits.
 * Assumes inclusion by bare name from the monitor's files.
 */
`ifndef FPM_PARAMS_SVH
`define FPM_PARAMS_SVH

`define FPM_OFF_CTRL        12'h000
`define FPM_OFF_STATUS      12'h004
`define FPM_OFF_MASK        12'h008
`define FPM_OFF_CAUSE       12'h00C
`define FPM_OFF_SEG         12'h010
`define FPM_OFF_SINGLE      12'h014
`define FPM_OFF_MULTI       12'h018
`define FPM_OFF_ALMHEAD     12'h01C
`define FPM_OFF_ALMPUSH     12'h020
`define FPM_OFF_LOAD        12'h024
`define FPM_OFF_VIEW        12'h028
`define FPM_OFF_SETUP       12'h02C

`define FPM_CTRL_LIMIT_BIT  0
`define FPM_CTRL_ZCLAMP_BIT 1
`define FPM_CTRL_IOSEL_BIT  2

`define FPM_VIEW_MAX        6'h2A
`define FPM_VIEW_DEFAULT    6'h22
`define FPM_ST_MAX          23'h7FFFFF
`define FPM_ALARM_DEPTH     14
`define FPM_LOAD_WARN       8'h55
`define FPM_CAUSE_NONE      4'h0
`define FPM_RESP_OKAY       2'h0
`define FPM_RESP_SLVERR     2'h2

`endif

// ===== fpm_pkg.sv
/*
 * Types of the front-panel monitor.
 * Assumes fpm_params.svh for the constant values.
 */
package fpm_pkg;

    typedef struct packed {
        logic       undervolt;
        logic       servo_on_input;
        logic       drive_alarm;
        logic       relay_closed;
        logic       estop;
        logic       pos_cmd_low;
        logic       torque_limited;
        logic       positive_limit_input;
        logic       negative_limit_input;
        logic       vel_cmd_pos;
        logic       vel_cmd_neg;
        logic       zero_clamp_input;
        logic       vel_mode_low;
        logic       torque_mode_low;
        logic       bus_estop;
    } fpm_status_s;

    typedef struct packed {
        logic       step;
        logic       ccw;
    } fpm_enc_s;

    typedef enum logic [1:0] {
        FPM_AX_IDLE = 2'b00,
        FPM_AX_RESP = 2'b01
    } fpm_axi_e;

endpackage : fpm_pkg

// ===== fpm_encoder_count.sv
/*
 * Single-turn and multiturn encoder counter with wrap.
 * Assumes one step pulse per count, on the module clock.
 */
`timescale 1ns/1ns
`include "fpm_params.svh"

module fpm_encoder_count
    import fpm_pkg::*;
#(
    parameter int ST_BITS = 23
)
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire fpm_enc_s            enc,
    output logic [ST_BITS-1:0]       single_turn,
    output logic signed [15:0]       multi_turn
);

    initial
    begin
        if (ST_BITS != 23)
            $error("fpm_encoder_count: only a 23-bit encoder is served");
    end

    // At a wrap, both counters move in one edge
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            single_turn <= '0;
            multi_turn  <= 16'sh0000;
        end
        else if (ce && enc.step)
        begin
            if (enc.ccw)
            begin
                if (single_turn == `FPM_ST_MAX)
                begin
                    single_turn <= '0;
                    multi_turn  <= multi_turn + 16'sh0001; // Wraps 32767 to -32768
                end
                else
                    single_turn <= single_turn + 23'h000001;
            end
            else
            begin
                if (single_turn == '0)
                begin
                    single_turn <= `FPM_ST_MAX;
                    multi_turn  <= multi_turn - 16'sh0001;
                end
                else
                    single_turn <= single_turn - 23'h000001;
            end
        end
    end

endmodule : fpm_encoder_count

// ===== fpm_front_panel.sv
/*
 * Front-panel monitor of a servo drive: I/O segment view, alarm
 * history, load warnings, not-running cause and encoder counters,
 * all reached over AXI4-Lite.
 * Assumes status inputs are asynchronous levels, keys are pins,
 * encoder steps and alarm pushes are on MCLK.
 */
`timescale 1ns/1ns
`include "fpm_params.svh"

module fpm_front_panel
    import fpm_pkg::*;
#(
    parameter int NCH = 10
)
(
    input  wire logic              MCLK,
    input  wire logic              NRST,
    input  wire logic              CE,
    input  wire logic [11:0]       S_AXI_AWADDR,
    input  wire logic              S_AXI_AWVALID,
    output logic                   S_AXI_AWREADY,
    input  wire logic [31:0]       S_AXI_WDATA,
    input  wire logic [3:0]        S_AXI_WSTRB,
    input  wire logic              S_AXI_WVALID,
    output logic                   S_AXI_WREADY,
    output logic [1:0]             S_AXI_BRESP,
    output logic                   S_AXI_BVALID,
    input  wire logic              S_AXI_BREADY,
    input  wire logic [11:0]       S_AXI_ARADDR,
    input  wire logic              S_AXI_ARVALID,
    output logic                   S_AXI_ARREADY,
    output logic [31:0]            S_AXI_RDATA,
    output logic [1:0]             S_AXI_RRESP,
    output logic                   S_AXI_RVALID,
    input  wire logic              S_AXI_RREADY,
    input  wire logic [NCH-1:0]    DIN,
    input  wire logic [NCH-1:0]    DOUT,
    input  wire fpm_status_s       STATUS,
    input  wire logic              KEY_UP,
    input  wire logic              KEY_DOWN,
    input  wire logic              KEY_SET,
    input  wire logic [7:0]        REGEN_LOAD,
    input  wire logic [7:0]        OVERLOAD,
    input  wire fpm_enc_s          ENC,
    output logic [NCH-1:0]         SEG_UPPER,
    output logic [NCH-1:0]         SEG_LOWER,
    output logic [NCH-1:0]         SEG_DP,
    output logic [7:0]             ALARM_SHOWN,
    output logic [3:0]             NO_RUN_CAUSE,
    output logic [5:0]             VIEW_SELECT,
    output logic                   IRQ
);

    initial
    begin
        if (NCH != 10)
            $error("fpm_front_panel: ten channels per view are served");
    end

    localparam int SYNC_W = 2 * NCH + $bits(fpm_status_s) + 3;

    // Two-stage synchronisers for pin inputs
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else if (CE)
        begin
            sync1_reg <= {DIN, DOUT, STATUS, KEY_UP, KEY_DOWN, KEY_SET};
            sync2_reg <= sync1_reg;
        end
    end

    logic [NCH-1:0] din_s;
    logic [NCH-1:0] dout_s;
    fpm_status_s    st_s;
    logic           key_up_s;
    logic           key_down_s;
    logic           key_set_s;

    assign {din_s, dout_s, st_s, key_up_s, key_down_s, key_set_s} = sync2_reg;

    logic key_up_q;
    logic key_down_q;
    logic key_set_q;

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            key_up_q   <= 1'b0;
            key_down_q <= 1'b0;
            key_set_q  <= 1'b0;
        end
        else if (CE)
        begin
            key_up_q   <= key_up_s;
            key_down_q <= key_down_s;
            key_set_q  <= key_set_s;
        end
    end

    logic up_press;
    logic down_press;
    logic set_press;

    assign up_press   = key_up_s && !key_up_q;
    assign down_press = key_down_s && !key_down_q;
    assign set_press  = key_set_s && !key_set_q;

    // Software-held registers
    logic [2:0]  ctrl_reg;
    logic [4:0]  status_reg;
    logic [4:0]  mask_reg;
    logic [5:0]  setup_reg = `FPM_VIEW_DEFAULT;
    logic [5:0]  view_reg;
    logic        view_loaded_reg;

    // Alarm history ring
    localparam int AD = `FPM_ALARM_DEPTH;
    logic [7:0] alarm_mem [AD];
    logic [3:0] alarm_wr_reg;
    logic [3:0] alarm_cnt_reg;
    logic [3:0] alarm_sel_reg;

    // Bus handshake
    logic        aw_seen_reg;
    logic        w_seen_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_fire;
    logic        rd_fire;

    assign S_AXI_AWREADY = !aw_seen_reg && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_seen_reg && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    assign wr_fire       = aw_seen_reg && w_seen_reg && !S_AXI_BVALID;
    assign rd_fire       = S_AXI_ARVALID && S_AXI_ARREADY;

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            aw_seen_reg  <= 1'b0;
            w_seen_reg   <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= '0;
            wstrb_reg    <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= `FPM_RESP_OKAY;
        end
        else if (CE)
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_seen_reg <= 1'b1;
                awaddr_reg  <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_seen_reg <= 1'b1;
                wdata_reg  <= S_AXI_WDATA;
                wstrb_reg  <= S_AXI_WSTRB;
            end
            if (wr_fire)
            begin
                aw_seen_reg  <= 1'b0;
                w_seen_reg   <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                case (awaddr_reg)
                    `FPM_OFF_CTRL, `FPM_OFF_MASK, `FPM_OFF_ALMPUSH, `FPM_OFF_SETUP:
                        S_AXI_BRESP <= `FPM_RESP_OKAY;
                    default:
                        S_AXI_BRESP <= `FPM_RESP_SLVERR;
                endcase
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
        end
    end

    logic wr_ctrl;
    logic wr_mask;
    logic wr_push;
    logic wr_setup;

    assign wr_ctrl  = wr_fire && awaddr_reg == `FPM_OFF_CTRL && wstrb_reg[0];
    assign wr_mask  = wr_fire && awaddr_reg == `FPM_OFF_MASK && wstrb_reg[0];
    assign wr_push  = wr_fire && awaddr_reg == `FPM_OFF_ALMPUSH && wstrb_reg[0];
    assign wr_setup = wr_fire && awaddr_reg == `FPM_OFF_SETUP && wstrb_reg[0];

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            ctrl_reg <= '0;
            mask_reg <= '0;
        end
        else if (CE)
        begin
            if (wr_ctrl)
                ctrl_reg <= wdata_reg[2:0];
            if (wr_mask)
                mask_reg <= wdata_reg[4:0];
        end
    end

    // Setting takes effect at the next restart only
    // Kept through NRST, so a restart picks it up
    always_ff @(posedge MCLK)
    begin
        if (CE && wr_setup && wdata_reg[5:0] <= `FPM_VIEW_MAX)
            setup_reg <= wdata_reg[5:0];
    end

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            view_reg        <= `FPM_VIEW_DEFAULT;
            view_loaded_reg <= 1'b0;
        end
        else if (CE && !view_loaded_reg)
        begin
            view_reg        <= setup_reg;
            view_loaded_reg <= 1'b1;
        end
    end

    // Alarm history: newest entry at index 0 of the browse
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            alarm_wr_reg  <= '0;
            alarm_cnt_reg <= '0;
            alarm_sel_reg <= '0;
        end
        else if (CE)
        begin
            if (wr_push)
            begin
                alarm_wr_reg  <= (alarm_wr_reg == 4'(AD - 1)) ? 4'h0 : alarm_wr_reg + 4'h1;
                if (alarm_cnt_reg != 4'(AD))
                    alarm_cnt_reg <= alarm_cnt_reg + 4'h1;
                alarm_sel_reg <= '0;
            end
            else if (up_press && alarm_cnt_reg != 4'h0
                     && alarm_sel_reg != alarm_cnt_reg - 4'h1)
                alarm_sel_reg <= alarm_sel_reg + 4'h1;
            else if (down_press && alarm_sel_reg != 4'h0)
                alarm_sel_reg <= alarm_sel_reg - 4'h1;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (CE && wr_push)
            alarm_mem[alarm_wr_reg] <= wdata_reg[7:0];
    end

    logic [4:0] alarm_idx;
    assign alarm_idx = (5'(alarm_wr_reg) + 5'(AD) - 5'd1 - 5'(alarm_sel_reg)) % 5'(AD);

    // Not-running cause, first match in code order
    logic [3:0] cause_next;

    always_comb
    begin
        cause_next = `FPM_CAUSE_NONE;
        if (st_s.undervolt)                                  cause_next = 4'h1;
        else if (!st_s.servo_on_input)                       cause_next = 4'h2;
        else if (!ctrl_reg[`FPM_CTRL_LIMIT_BIT]
                 && ((!st_s.positive_limit_input && st_s.vel_cmd_pos)
                  || (!st_s.negative_limit_input && st_s.vel_cmd_neg)))
                                                             cause_next = 4'h3;
        else if (st_s.drive_alarm)                           cause_next = 4'h4;
        else if (!st_s.relay_closed)                         cause_next = 4'h5;
        else if (st_s.estop)                                 cause_next = 4'h6;
        else if (st_s.pos_cmd_low)                           cause_next = 4'h7;
        else if (st_s.torque_limited)                        cause_next = 4'h8;
        else if (ctrl_reg[`FPM_CTRL_ZCLAMP_BIT] && !st_s.zero_clamp_input)
                                                             cause_next = 4'h9;
        else if (st_s.vel_mode_low)                          cause_next = 4'hA;
        else if (st_s.torque_mode_low)                       cause_next = 4'hC;
        else if (st_s.bus_estop)                             cause_next = 4'hD;
    end

    // Segment drive for the I/O view
    logic [NCH-1:0] io_sel;
    assign io_sel = ctrl_reg[`FPM_CTRL_IOSEL_BIT] ? dout_s : din_s;

    logic [4:0] event_now;
    logic       cause_q;
    logic       regen_q;
    logic       over_q;
    logic       regen_warn;
    logic       over_warn;

    assign regen_warn = REGEN_LOAD >= `FPM_LOAD_WARN;
    assign over_warn  = OVERLOAD >= `FPM_LOAD_WARN;

    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            SEG_UPPER    <= '0;
            SEG_LOWER    <= '0;
            SEG_DP       <= '0;
            ALARM_SHOWN  <= '0;
            NO_RUN_CAUSE <= `FPM_CAUSE_NONE;
            VIEW_SELECT  <= `FPM_VIEW_DEFAULT;
            cause_q      <= 1'b0;
            regen_q      <= 1'b0;
            over_q       <= 1'b0;
        end
        else if (CE)
        begin
            // Bit i is digit i from the right, channel i+1
            SEG_UPPER    <= io_sel;
            SEG_LOWER    <= ~io_sel;
            SEG_DP       <= {NCH{!ctrl_reg[`FPM_CTRL_IOSEL_BIT]}};
            ALARM_SHOWN  <= (alarm_cnt_reg == 4'h0) ? 8'h00 : alarm_mem[alarm_idx[3:0]];
            NO_RUN_CAUSE <= cause_next;
            VIEW_SELECT  <= view_reg;
            cause_q      <= cause_next != `FPM_CAUSE_NONE;
            regen_q      <= regen_warn;
            over_q       <= over_warn;
        end
    end

    // Events: new cause, regen warn, overload warn, alarm push, set key
    assign event_now = {set_press, wr_push, over_warn && !over_q,
                        regen_warn && !regen_q,
                        (cause_next != `FPM_CAUSE_NONE) && !cause_q};

    logic rd_status;
    assign rd_status = rd_fire && S_AXI_ARADDR == `FPM_OFF_STATUS;

    // Set wins over the read-clear
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
            status_reg <= '0;
        else if (CE)
            status_reg <= (rd_status ? 5'h00 : status_reg) | event_now;
    end

    assign IRQ = |(status_reg & mask_reg);

    // Encoder counters
    logic [22:0]        single_turn;
    logic signed [15:0] multi_turn;

    fpm_encoder_count #(
        .ST_BITS     (23)
    ) u_enc (
        .clk         (MCLK),
        .rst_n       (NRST),
        .ce          (CE),
        .enc         (ENC),
        .single_turn (single_turn),
        .multi_turn  (multi_turn)
    );

    // Read channel
    always_ff @(posedge MCLK or negedge NRST)
    begin
        if (!NRST)
        begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= '0;
            S_AXI_RRESP  <= `FPM_RESP_OKAY;
        end
        else if (CE)
        begin
            if (rd_fire)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP  <= `FPM_RESP_OKAY;
                case (S_AXI_ARADDR)
                    `FPM_OFF_CTRL:    S_AXI_RDATA <= {29'h0, ctrl_reg};
                    `FPM_OFF_STATUS:  S_AXI_RDATA <= {27'h0, status_reg};
                    `FPM_OFF_MASK:    S_AXI_RDATA <= {27'h0, mask_reg};
                    `FPM_OFF_CAUSE:   S_AXI_RDATA <= {28'h0, cause_next};
                    `FPM_OFF_SEG:     S_AXI_RDATA <= {2'h0, SEG_DP, SEG_LOWER, SEG_UPPER};
                    `FPM_OFF_SINGLE:  S_AXI_RDATA <= {9'h0, single_turn};
                    `FPM_OFF_MULTI:   S_AXI_RDATA <= {{16{multi_turn[15]}}, multi_turn};
                    `FPM_OFF_ALMHEAD: S_AXI_RDATA <= {16'h0, alarm_cnt_reg, alarm_sel_reg,
                                                      ALARM_SHOWN};
                    `FPM_OFF_LOAD:    S_AXI_RDATA <= {16'h0, OVERLOAD, REGEN_LOAD};
                    `FPM_OFF_VIEW:    S_AXI_RDATA <= {26'h0, view_reg};
                    `FPM_OFF_SETUP:   S_AXI_RDATA <= {26'h0, setup_reg};
                    `FPM_OFF_ALMPUSH: S_AXI_RDATA <= '0;
                    default:
                    begin
                        S_AXI_RDATA <= '0;
                        S_AXI_RRESP <= `FPM_RESP_SLVERR;
                    end
                endcase
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
        end
    end

endmodule : fpm_front_panel

// ===== fpm_front_panel_properties.sv
/*
 * Port assertions of the front-panel monitor.
 * Assumes a bind from the bench top file onto fpm_front_panel.
 */
`timescale 1ns/1ns

module fpm_front_panel_properties
    import fpm_pkg::*;
#(
    parameter int NCH = 10
)
(
    input wire logic           MCLK,
    input wire logic           NRST,
    input wire logic           S_AXI_AWVALID,
    input wire logic           S_AXI_AWREADY,
    input wire logic           S_AXI_WVALID,
    input wire logic           S_AXI_WREADY,
    input wire logic           S_AXI_BVALID,
    input wire logic           S_AXI_ARVALID,
    input wire logic           S_AXI_ARREADY,
    input wire logic           S_AXI_RVALID,
    input wire logic [NCH-1:0] SEG_UPPER,
    input wire logic [NCH-1:0] SEG_LOWER,
    input wire logic [NCH-1:0] SEG_DP,
    input wire logic [3:0]     NO_RUN_CAUSE,
    input wire logic [5:0]     VIEW_SELECT
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!NRST);

    property p_seg_pair; $past(NRST) |-> SEG_LOWER == ~SEG_UPPER; endproperty
    a_seg_pair: assert property (p_seg_pair) else $error("segment halves not opposite");
    property p_dp_whole; SEG_DP == '0 || SEG_DP == '1; endproperty
    a_dp_whole: assert property (p_dp_whole) else $error("decimal points mixed");
    property p_cause_set; !(NO_RUN_CAUSE inside {4'hB, 4'hE, 4'hF}); endproperty
    a_cause_set: assert property (p_cause_set) else $error("cause code undefined");
    property p_view_range; VIEW_SELECT <= 6'h2A; endproperty
    a_view_range: assert property (p_view_range) else $error("view out of range");
    property p_view_hold; $past(NRST, 3) |-> $stable(VIEW_SELECT); endproperty
    a_view_hold: assert property (p_view_hold) else $error("view changed in run");
    property p_ar_block; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
    a_ar_block: assert property (p_ar_block) else $error("read taken during answer");
    property p_aw_block; S_AXI_BVALID |-> !S_AXI_AWREADY; endproperty
    a_aw_block: assert property (p_aw_block) else $error("write taken during answer");
    property p_r_next; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
    a_r_next: assert property (p_r_next) else $error("read answer late");
    property p_b_time;
        S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##[1:2] S_AXI_BVALID;
    endproperty
    a_b_time: assert property (p_b_time) else $error("write answer late");
endmodule : fpm_front_panel_properties

// ===== fpm_operator_model.sv
/*
 * Operator at the front panel pressing up, down and set.
 * Assumes the panel synchronises keys to MCLK.
 */
`timescale 1ns/1ns

module fpm_operator_model
(
    input  wire logic MCLK,
    output logic      KEY_UP,
    output logic      KEY_DOWN,
    output logic      KEY_SET
);
    initial {KEY_UP, KEY_DOWN, KEY_SET} = 3'h0;

    // Held long enough to pass the synchroniser; set only raises a status event
    task automatic press(input logic [2:0] k);
        @(posedge MCLK);
        {KEY_UP, KEY_DOWN, KEY_SET} <= k;
        repeat (4) @(posedge MCLK);
        {KEY_UP, KEY_DOWN, KEY_SET} <= 3'h0;
        repeat (4) @(posedge MCLK);
    endtask : press
endmodule : fpm_operator_model

// ===== fpm_front_panel_bench.sv
/*
 * Self-checking bench of the front-panel monitor.
 * Assumes the monitor, its package and the operator model.
 */
`timescale 1ns/1ns
`include "fpm_params.svh"

module fpm_front_panel_bench
    import fpm_pkg::*;
;
    localparam logic [14:0] BASE = 15'h28C8;
    localparam logic [14:0] XM [14] = '{15'h4000, 15'h2000, 15'h00A0, 15'h0050, 15'h1000,
        15'h0800, 15'h0400, 15'h0200, 15'h0100, 15'h0008, 15'h0004, 15'h0002, 15'h0001, 15'h0};
    localparam logic [3:0] XC [14] = '{4'h1, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
        4'h9, 4'hA, 4'hC, 4'hD, 4'h0};
    logic        mclk, nrst, ce, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid;
    logic        arrdy, rvalid, irq, k_up, k_dn, k_set;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp;
    logic [9:0]  din, dout, seg_up, seg_lo, seg_dp;
    logic [7:0]  regen, ovl, alarm;
    logic [3:0]  cause, strb;
    logic [5:0]  view;
    fpm_status_s status;
    fpm_enc_s    enc;
    int          num_errors, checked;

    fpm_front_panel #(.NCH(10)) i_dut (.MCLK(mclk), .NRST(nrst), .CE(ce),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata),
        .S_AXI_WSTRB(strb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
        .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .DIN(din), .DOUT(dout), .STATUS(status),
        .KEY_UP(k_up), .KEY_DOWN(k_dn), .KEY_SET(k_set), .REGEN_LOAD(regen), .OVERLOAD(ovl),
        .ENC(enc), .SEG_UPPER(seg_up), .SEG_LOWER(seg_lo), .SEG_DP(seg_dp),
        .ALARM_SHOWN(alarm), .NO_RUN_CAUSE(cause), .VIEW_SELECT(view), .IRQ(irq));
    fpm_operator_model i_op (.MCLK(mclk), .KEY_UP(k_up), .KEY_DOWN(k_dn), .KEY_SET(k_set));

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // Each request held until its ready is seen at a rising edge
    task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [1:0] er);
        logic ta = 1'h0;
        logic tw = 1'h0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        awv <= 1'h1;
        wv <= 1'h1;
        bready <= 1'h1;
        do
        begin
            @(posedge mclk);
            ta = ta || awrdy;
            tw = tw || wrdy;
            if (ta) awv <= 1'h0;
            if (tw) wv <= 1'h0;
        end while (!(ta && tw));
        do @(posedge mclk); while (!bvalid);
        bready <= 1'h0;
        chk("bresp", bresp, er);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] v);
        @(posedge mclk);
        araddr <= a;
        arv <= 1'h1;
        rready <= 1'h1;
        do @(posedge mclk); while (!arrdy);
        arv <= 1'h0;
        do @(posedge mclk); while (!rvalid);
        v = rdata;
        rready <= 1'h0;
        chk("rresp", rresp, er);
    endtask : rd

    task automatic t_io;
        din <= 10'h281;
        dout <= 10'h001;
        repeat (5) @(posedge mclk);
        chk("seg_up in", seg_up, 10'h281);
        chk("seg_lo in", seg_lo, 10'h17E);
        chk("seg_dp in", seg_dp, 10'h3FF);
        rd(`FPM_OFF_SEG, 2'h0, d);
        chk("seg reg", d, 32'h3FF5FA81);
        wr(`FPM_OFF_CTRL, 32'h4, 2'h0);
        repeat (5) @(posedge mclk);
        chk("seg_up out", seg_up, 10'h001);
        chk("seg_lo out", seg_lo, 10'h3FE);
        chk("seg_dp out", seg_dp, 10'h000);
    endtask : t_io

    task automatic t_cause;
        wr(`FPM_OFF_MASK, 32'h1, 2'h0);
        wr(`FPM_OFF_CTRL, 32'h2, 2'h0);
        rd(`FPM_OFF_STATUS, 2'h0, d);
        chk("irq idle", irq, 1'h0);
        for (int i = 0; i < 14; i++)
        begin
            status <= fpm_status_s'(BASE ^ XM[i]);
            repeat (5) @(posedge mclk);
            chk("cause", cause, XC[i]);
            rd(`FPM_OFF_CAUSE, 2'h0, d);
            chk("cause reg", d, XC[i]);
            if (i == 0)
            begin
                chk("irq set", irq, 1'h1);
                rd(`FPM_OFF_STATUS, 2'h0, d);
                @(posedge mclk);
                chk("irq clear", irq, 1'h0);
            end
        end
        wr(`FPM_OFF_CTRL, 32'h1, 2'h0);
        status <= fpm_status_s'(BASE ^ 15'h00A0);
        repeat (5) @(posedge mclk);
        chk("limit off", cause, 4'h0);
        status <= fpm_status_s'(BASE ^ 15'h0008);
        repeat (5) @(posedge mclk);
        chk("clamp off", cause, 4'h0);
    endtask : t_cause

    task automatic t_alarm;
        for (int i = 1; i < 16; i++)
            wr(`FPM_OFF_ALMPUSH, 32'(i), 2'h0);
        repeat (2) @(posedge mclk);
        chk("newest", alarm, 8'h0F);
        repeat (14) i_op.press(3'h4);
        chk("oldest", alarm, 8'h02);
        i_op.press(3'h2);
        chk("newer", alarm, 8'h03);
        rd(`FPM_OFF_ALMHEAD, 2'h0, d);
        chk("count", d[15:12], 4'hE);
    endtask : t_alarm

    task automatic t_load;
        regen <= 8'h56;
        ovl <= 8'h60;
        i_op.press(3'h1);
        rd(`FPM_OFF_LOAD, 2'h0, d);
        chk("load", d, 32'h6056);
        rd(`FPM_OFF_STATUS, 2'h0, d);
        chk("events", d & 32'h1E, 32'h1E);
        rd(`FPM_OFF_STATUS, 2'h0, d);
        chk("cleared", d & 32'h1E, 32'h0);
        regen <= 8'h00;
        repeat (3) @(posedge mclk);
        regen <= 8'h56;
        repeat (3) @(posedge mclk);
        chk("irq masked", irq, 1'h0);
    endtask : t_load

    task automatic t_enc(input logic [1:0] e, input logic c, input logic [31:0] st,
                         input logic [31:0] mt);
        @(posedge mclk);
        enc <= e;
        ce <= c;
        @(posedge mclk);
        enc <= 2'h0;
        ce <= 1'h1;
        rd(`FPM_OFF_SINGLE, 2'h0, d);
        chk("single", d, st);
        rd(`FPM_OFF_MULTI, 2'h0, d);
        chk("multi", d, mt);
    endtask : t_enc

    task automatic t_bus;
        chk("view reset", view, 6'h22);
        rd(12'hFFC, 2'h2, d);
        chk("unmapped", d, 32'h0);
        wr(`FPM_OFF_CAUSE, 32'h5, 2'h2);
        wr(`FPM_OFF_SETUP, 32'h5, 2'h0);
        strb <= 4'hE;
        wr(`FPM_OFF_SETUP, 32'h7, 2'h0);
        strb <= 4'hF;
        rd(`FPM_OFF_SETUP, 2'h0, d);
        chk("setup", d, 32'h5);
        chk("view kept", view, 6'h22);
        nrst <= 1'h0;
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        repeat (3) @(posedge mclk);
        chk("view restart", view, 6'h05);
    endtask : t_bus

    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    initial
    begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    initial
    begin
        repeat (30000) @(posedge mclk);
        num_errors++;
        conclude();
    end

    initial
    begin
        {nrst, awv, wv, bready, arv, rready, awaddr, araddr, wdata} = '0;
        {din, dout, regen, ovl, enc, ce, strb} = {38'h0, 5'h1F};
        status = fpm_status_s'(BASE);
        repeat (20) @(posedge mclk);
        nrst <= 1'h1;
        t_bus();
        t_io();
        t_cause();
        t_alarm();
        t_load();
        t_enc(2'h2, 1'h1, 32'h7FFFFF, 32'hFFFFFFFF);
        t_enc(2'h3, 1'h1, 32'h0, 32'h0);
        t_enc(2'h3, 1'h0, 32'h0, 32'h0);
        conclude();
    end
endmodule : fpm_front_panel_bench

bind fpm_front_panel fpm_front_panel_properties #(.NCH(NCH)) i_props (.MCLK, .NRST,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID, .SEG_UPPER, .SEG_LOWER, .SEG_DP,
    .NO_RUN_CAUSE, .VIEW_SELECT);
